// ===== design/adcsm_pkg.sv
// Constants and types for the converter status and mode register bank
package adcsm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_CH = 8;
    localparam logic [7:0] ADDR_ID = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_MODE = 8'h02;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h11;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h12;
    // Identification upper byte; value is arbitrary
    localparam logic [7:0] ID_UPPER = 8'h5A;
    // Identification lower byte; value is arbitrary
    localparam logic [7:0] ID_LOWER = 8'h00;
    localparam logic [15:0] STATUS_RST = 16'h0500;
    localparam logic [15:0] MODE_RST = 16'h0510;
    localparam logic [15:0] MODE_WMASK = 16'h3F1F;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam int ST_LOCK = 15;
    localparam int ST_RESYNC = 14;
    localparam int ST_MAPCRC = 13;
    localparam int ST_CRCERR = 12;
    localparam int MD_CRC_TYPE = 11;
    localparam int MD_RESET = 10;
    localparam int MD_WLEN_LO = 8;
    localparam int MD_TIMEOUT = 4;
    localparam int MD_SEL_LO = 2;
    localparam int MD_IDLE_FLOAT = 1;
    localparam int MD_PULSE_FMT = 0;
    localparam int MD_IN_CRC_EN = 12;
    localparam int MD_MAP_CRC_EN = 13;
    localparam int IRQ_RESYNC = 0;
    localparam int IRQ_MAPCRC = 1;
    localparam int IRQ_CRCERR = 2;
    localparam int IRQ_TIMEOUT = 3;
    localparam int CLK_HZ = 25000000;
    localparam int PULSE_NS = 160;
    localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int TIMEOUT_US = 1000;
    localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1000000);
    typedef enum logic [1:0] {
        SRC_LAGGING = 2'b00,
        SRC_ANY = 2'b01,
        SRC_LEADING = 2'b10,
        SRC_LEADING_ALT = 2'b11
    } adcsm_src_e;
endpackage

// ===== design/adcsm_regs.sv
// Identification, status and mode register bank of the converter
// Behaviour
// - Identification register at 00h, read-only, fixed identity in upper byte.
// - Status register read-only at 01h, value 0500h after reset.
// - Status bit 15 shows serial interface lock, follows its input even in reset.
// - Status bit 14 sets on every resynchronization, zero after reset.
// - Status bit 13 shows register map checksum changed, resets zero.
// - Status bit 12 shows input checksum error detected, resets zero.
// - Status bit 11 shows checksum type, 0 CCITT, 1 ANSI.
// - Status bit 10 shows a reset occurred, one right after reset.
// - Status bits 9:8 show word length with four encodings.
// - Status bits 7:0 flag new data per channel, reset zero.
// - Mode register read/write at 02h, value 0510h after reset.
// - Every field holds its documented default after reset.
// - Mode word length field selects output word length, default 01b.
// - Mode checksum type bit selects polynomial for link and map.
// - Ready pin source: lagging, OR of enabled, or leading channel.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module adcsm_regs
    import adcsm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    input wire logic ifaceLocked,
    input wire logic resyncEvt,
    input wire logic mapCrcChangeEvt,
    input wire logic inCrcErrEvt,
    input wire logic [NUM_CH-1:0] chanNewData,
    input wire logic [NUM_CH-1:0] chanDataTaken,
    input wire logic [NUM_CH-1:0] chanEnable,
    input wire logic linkClk,
    input wire logic linkSelN,
    output logic readyPinOut,
    output logic readyPinOeN,
    output logic [1:0] wordSizeSelect,
    output logic crcAnsiSelect,
    output logic inCrcEnable,
    output logic mapCrcEnable,
    output logic irq
);
    logic [15:0] mode_ff;
    logic [15:0] nxt_mode;
    logic [2:0] flags_ff;
    logic [2:0] nxt_flags;
    logic [NUM_CH-1:0] newData_ff;
    logic [NUM_CH-1:0] nxt_newData;
    logic [3:0] irqStat_ff;
    logic [3:0] nxt_irqStat;
    logic [3:0] irqEn_ff;
    logic [3:0] nxt_irqEn;
    logic [15:0] rdData_ff;
    logic [2:0] linkClkSync_ff;
    logic [1:0] linkSelSync_ff;
    logic [31:0] idleCnt_ff;
    logic [31:0] nxt_idleCnt;
    logic timeoutHit_ff;
    logic [7:0] pulseCnt_ff;
    logic [7:0] nxt_pulseCnt;
    logic readyCond_ff;
    logic readyPinOut_ff;
    logic readyPinOeN_ff;

    wire wrMode = regWr && (regAddr == ADDR_MODE);
    wire wrIrqClr = regWr && (regAddr == ADDR_IRQ_CLR);
    wire wrIrqEn = regWr && (regAddr == ADDR_IRQ_EN);
    wire rdStatus = regRd && (regAddr == ADDR_STATUS);

    // Only documented fields are writable; reserved positions stay zero
    assign nxt_mode = wrMode ? (regWrData & MODE_WMASK) : mode_ff;

    // Sticky event flags clear on a status read; a new event wins
    wire [2:0] flagEvt = {resyncEvt, mapCrcChangeEvt, inCrcErrEvt};
    assign nxt_flags = flagEvt | (rdStatus ? 3'h0 : flags_ff);
    assign nxt_newData = chanNewData | (newData_ff & ~chanDataTaken);

    wire [15:0] statusWord = {ifaceLocked, flags_ff,
        mode_ff[MD_CRC_TYPE], mode_ff[MD_RESET],
        mode_ff[MD_WLEN_LO +: 2], newData_ff};
    wire [15:0] idWord = {ID_UPPER, ID_LOWER};

    // Link clock and select are asynchronous pins: two flops first
    wire linkEdge = linkClkSync_ff[2] ^ linkClkSync_ff[1];
    wire linkActive = ~linkSelSync_ff[1];
    wire timeoutOn = mode_ff[MD_TIMEOUT];
    wire timeoutNow = timeoutOn && linkActive && !linkEdge
        && (idleCnt_ff == 32'(TIMEOUT_CYCLES - 1));
    assign nxt_idleCnt = (!linkActive || linkEdge || !timeoutOn
        || timeoutNow) ? 32'h0 : idleCnt_ff + 32'h1;

    wire [3:0] irqEvt;
    assign irqEvt[IRQ_RESYNC] = resyncEvt;
    assign irqEvt[IRQ_MAPCRC] = mapCrcChangeEvt;
    assign irqEvt[IRQ_CRCERR] = inCrcErrEvt;
    assign irqEvt[IRQ_TIMEOUT] = timeoutHit_ff;
    wire [3:0] irqClrMask = wrIrqClr ? regWrData[3:0] : 4'h0;
    assign nxt_irqStat = irqEvt | (irqStat_ff & ~irqClrMask);
    assign nxt_irqEn = wrIrqEn ? regWrData[3:0] : irqEn_ff;
    assign irq = |(irqStat_ff & irqEn_ff);

    // Ready source over enabled channels only
    wire [NUM_CH-1:0] enReady = newData_ff & chanEnable;
    wire anyEnabled = |chanEnable;
    wire lagReady = anyEnabled && ((enReady | ~chanEnable) == 8'hFF);
    wire [NUM_CH-1:0] firstEn = chanEnable & (~chanEnable + 8'h01);
    wire leadReady = |(firstEn & newData_ff);
    adcsm_src_e srcSel;
    assign srcSel = adcsm_src_e'(mode_ff[MD_SEL_LO +: 2]);
    logic readyCond;
    always_comb begin
        unique case (srcSel)
            SRC_LAGGING: readyCond = lagReady;
            SRC_ANY: readyCond = |enReady;
            SRC_LEADING, SRC_LEADING_ALT: readyCond = leadReady;
        endcase
    end
    wire readyRise = readyCond && !readyCond_ff;
    assign nxt_pulseCnt = readyRise ? 8'(PULSE_CYC)
        : (pulseCnt_ff != 8'h00) ? pulseCnt_ff - 8'h01 : 8'h00;
    wire pulseMode = mode_ff[MD_PULSE_FMT];
    wire pinLow = pulseMode ? (nxt_pulseCnt != 8'h00) : readyCond;
    // Floating idle leaves the pin to the board pull-up
    wire pinOeN = !pinLow && mode_ff[MD_IDLE_FLOAT];

    wire [15:0] rdMux =
        (regAddr == ADDR_ID) ? idWord :
        (regAddr == ADDR_STATUS) ? statusWord :
        (regAddr == ADDR_MODE) ? mode_ff :
        (regAddr == ADDR_IRQ_STAT) ? {12'h000, irqStat_ff} :
        (regAddr == ADDR_IRQ_EN) ? {12'h000, irqEn_ff} : 16'h0000;

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_ff <= MODE_RST;
            flags_ff <= 3'h0;
            newData_ff <= '0;
        end else begin
            mode_ff <= nxt_mode;
            flags_ff <= nxt_flags;
            newData_ff <= nxt_newData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irqStat_ff <= IRQ_RST;
            irqEn_ff <= IRQ_RST;
            rdData_ff <= 16'h0000;
        end else begin
            irqStat_ff <= nxt_irqStat;
            irqEn_ff <= nxt_irqEn;
            rdData_ff <= regRd ? rdMux : 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            linkClkSync_ff <= 3'h0;
            linkSelSync_ff <= 2'h3;
            idleCnt_ff <= 32'h0;
            timeoutHit_ff <= 1'b0;
        end else begin
            linkClkSync_ff <= {linkClkSync_ff[1:0], linkClk};
            linkSelSync_ff <= {linkSelSync_ff[0], linkSelN};
            idleCnt_ff <= nxt_idleCnt;
            timeoutHit_ff <= timeoutNow;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pulseCnt_ff <= 8'h00;
            readyCond_ff <= 1'b0;
            readyPinOut_ff <= 1'b1;
            readyPinOeN_ff <= 1'b0;
        end else begin
            pulseCnt_ff <= nxt_pulseCnt;
            readyCond_ff <= readyCond;
            readyPinOut_ff <= !pinLow;
            readyPinOeN_ff <= pinOeN;
        end
    end

    assign regRdData = rdData_ff;
    assign readyPinOut = readyPinOut_ff;
    assign readyPinOeN = readyPinOeN_ff;
    assign wordSizeSelect = mode_ff[MD_WLEN_LO +: 2];
    assign crcAnsiSelect = mode_ff[MD_CRC_TYPE];
    assign inCrcEnable = mode_ff[MD_IN_CRC_EN];
    assign mapCrcEnable = mode_ff[MD_MAP_CRC_EN];

    // Assertion helpers
    logic pastValid_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            pastValid_ff <= 1'b0;
        end else begin
            pastValid_ff <= 1'b1;
        end
    end

    property p_id_read;
        @(posedge clk) disable iff (srst)
        regRd && regAddr == ADDR_ID |=> regRdData[15:8] == ID_UPPER;
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("ID upper byte wrong");

    // Lock bit follows its input even in reset, so it is left out
    property p_status_reset;
        @(posedge clk) srst |=> statusWord[14:0] == STATUS_RST[14:0];
    endproperty
    a_status_reset: assert property (p_status_reset)
        else $error("Status not 0500h after reset");

    property p_mode_reset;
        @(posedge clk) srst |=> mode_ff == MODE_RST;
    endproperty
    a_mode_reset: assert property (p_mode_reset)
        else $error("Mode not 0510h after reset");

    property p_lock;
        @(posedge clk) disable iff (srst)
        rdStatus |=> regRdData[ST_LOCK] == $past(ifaceLocked);
    endproperty
    a_lock: assert property (p_lock)
        else $error("Lock bit wrong");

    property p_resync_sticky;
        @(posedge clk) disable iff (srst)
        resyncEvt ##1 !rdStatus |=> flags_ff[2];
    endproperty
    a_resync_sticky: assert property (p_resync_sticky)
        else $error("Resync flag lost");

    property p_newdata;
        @(posedge clk) disable iff (srst)
        chanNewData[0] |=> newData_ff[0];
    endproperty
    a_newdata: assert property (p_newdata)
        else $error("Channel new-data flag lost");

    property p_mirror;
        @(posedge clk) disable iff (srst)
        wrMode |=> statusWord[11:8] == $past(regWrData[11:8]);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("Status does not mirror mode");

    property p_reserved;
        @(posedge clk) disable iff (srst)
        regRd && regAddr == ADDR_MODE |=>
            regRdData[15:14] == 2'b00 && regRdData[7:5] == 3'b000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Mode reserved bits not zero");

    property p_reset_clear;
        @(posedge clk) disable iff (srst)
        wrMode && !regWrData[MD_RESET] |=> !statusWord[10];
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Reset bit not cleared");

    property p_or_source;
        @(posedge clk) disable iff (srst)
        pastValid_ff && srcSel == SRC_ANY && !pulseMode && |enReady
            |=> !readyPinOut;
    endproperty
    a_or_source: assert property (p_or_source)
        else $error("Ready pin not low for OR source");

    // Channel 0, when enabled, is always the leading one
    property p_lead_source;
        @(posedge clk) disable iff (srst)
        mode_ff[MD_SEL_LO + 1] && !pulseMode && chanEnable[0]
            && newData_ff[0] |=> !readyPinOut;
    endproperty
    a_lead_source: assert property (p_lead_source)
        else $error("Ready pin not low for leading source");

    property p_lag_source;
        @(posedge clk) disable iff (srst)
        mode_ff[MD_SEL_LO +: 2] == 2'b00 && !pulseMode
            && (newData_ff & chanEnable) != chanEnable |=> readyPinOut;
    endproperty
    a_lag_source: assert property (p_lag_source)
        else $error("Ready pin low before all enabled channels");

    c_timeout: cover property (@(posedge clk) disable iff (srst)
        timeoutHit_ff);
    c_irq: cover property (@(posedge clk) disable iff (srst) irq);
    c_lagging: cover property (@(posedge clk) disable iff (srst)
        srcSel == SRC_LAGGING && lagReady);
    c_pulse: cover property (@(posedge clk) disable iff (srst)
        pulseMode && readyRise);
endmodule // adcsm_regs

// ===== tb/adcsm_host_model.sv
// Serial host model: frame select and link clock seen by the bank
`timescale 1ns/1ns
module adcsm_host_model (
    input wire logic frameOn,
    input wire logic clockRun,
    output logic linkClk,
    output logic linkSelN
);
    initial linkClk = 1'b0;
    // Clock stands still outside frames, as the real host does
    always #160 linkClk = (frameOn && clockRun) ? ~linkClk : 1'b0;
    assign linkSelN = ~frameOn;
endmodule // adcsm_host_model

// ===== tb/adcsm_regs_tb.sv
// Self-checking bench for the status and mode register bank
`timescale 1ns/1ns
module adcsm_regs_tb;
    import adcsm_pkg::*;
    logic clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000, regRdData, d;
    logic ifaceLocked = 1'b0, resyncEvt = 1'b0, mapCrcChangeEvt = 1'b0;
    logic inCrcErrEvt = 1'b0, frameOn = 1'b0, clockRun = 1'b0;
    logic [7:0] chanNewData = 8'h00, chanDataTaken = 8'h00;
    logic [7:0] chanEnable = 8'h01;
    logic linkClk, linkSelN, readyPinOut, readyPinOeN, crcAnsiSelect, irq;
    logic inCrcEnable, mapCrcEnable;
    logic [1:0] wordSizeSelect;
    int failCount = 0, nCompared = 0, cyc = 0;
    adcsm_regs #(.TIMEOUT_CYCLES(20)) DUT (.clk(clk), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .ifaceLocked(ifaceLocked),
        .resyncEvt(resyncEvt), .mapCrcChangeEvt(mapCrcChangeEvt),
        .inCrcErrEvt(inCrcErrEvt), .chanNewData(chanNewData),
        .chanDataTaken(chanDataTaken), .chanEnable(chanEnable),
        .linkClk(linkClk), .linkSelN(linkSelN), .readyPinOut(readyPinOut),
        .readyPinOeN(readyPinOeN), .wordSizeSelect(wordSizeSelect),
        .crcAnsiSelect(crcAnsiSelect), .inCrcEnable(inCrcEnable),
        .mapCrcEnable(mapCrcEnable), .irq(irq));
    adcsm_host_model host (.frameOn(frameOn), .clockRun(clockRun),
        .linkClk(linkClk), .linkSelN(linkSelN));
    initial forever #20 clk = ~clk;
    task automatic final_report;
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard: the whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failCount++;
            final_report;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_reset_and_refusal;
        rd(ADDR_ID, d);
        chk({8'h00, d[15:8]}, {8'h00, ID_UPPER});
        rd(ADDR_STATUS, d);
        chk(d, 16'h0500);
        rd(ADDR_MODE, d);
        chk(d, 16'h0510);
        rd(8'h3F, d);
        chk(d, 16'h0000);
        wr(ADDR_STATUS, 16'hFFFF);
        wr(ADDR_ID, 16'h0000);
        rd(ADDR_STATUS, d);
        chk(d, 16'h0500);
        rd(ADDR_ID, d);
        chk({8'h00, d[15:8]}, {8'h00, ID_UPPER});
    endtask
    task automatic t_mode_fields;
        wr(ADDR_MODE, 16'hFFFF);
        rd(ADDR_MODE, d);
        chk(d, 16'h3F1F);
        rd(ADDR_STATUS, d);
        chk(d, 16'h0F00);
        chk({12'h000, mapCrcEnable, inCrcEnable, crcAnsiSelect, 1'b0},
            16'h000E);
        for (int w = 0; w < 4; w++) begin
            // Reset flag written 0 here, so status bit 10 must drop
            wr(ADDR_MODE, {6'h00, 2'(w), 8'h10});
            rd(ADDR_STATUS, d);
            chk(d, {6'h00, 2'(w), 8'h00});
            chk({14'h0000, wordSizeSelect}, 16'(w));
        end
        wr(ADDR_MODE, 16'h0510);
    endtask
    task automatic t_status_events;
        @(posedge clk);
        ifaceLocked <= 1'b1;
        {resyncEvt, mapCrcChangeEvt, inCrcErrEvt} <= 3'b111;
        chanNewData <= 8'h81;
        @(posedge clk);
        {resyncEvt, mapCrcChangeEvt, inCrcErrEvt} <= 3'b000;
        chanNewData <= 8'h00;
        rd(ADDR_STATUS, d);
        chk(d, 16'hF581);
        rd(ADDR_STATUS, d);
        chk(d, 16'h8581);
        @(posedge clk);
        chanDataTaken <= 8'h81;
        ifaceLocked <= 1'b0;
        @(posedge clk);
        chanDataTaken <= 8'h00;
        rd(ADDR_STATUS, d);
        chk(d, 16'h0500);
    endtask
    task automatic t_irq_and_timeout;
        wr(ADDR_IRQ_CLR, 16'h000F);
        wr(ADDR_IRQ_EN, 16'h0004);
        @(posedge clk);
        inCrcErrEvt <= 1'b1;
        @(posedge clk);
        inCrcErrEvt <= 1'b0;
        cycles(2);
        chk({15'h0000, irq}, 16'h0001);
        wr(ADDR_IRQ_CLR, 16'h0004);
        cycles(1);
        chk({15'h0000, irq}, 16'h0000);
        @(posedge clk);
        resyncEvt <= 1'b1;
        @(posedge clk);
        resyncEvt <= 1'b0;
        rd(ADDR_IRQ_STAT, d);
        chk(d, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        wr(ADDR_IRQ_CLR, 16'h0001);
        wr(ADDR_IRQ_EN, 16'h0008);
        frameOn <= 1'b1;
        clockRun <= 1'b1;
        cycles(60);
        rd(ADDR_IRQ_STAT, d);
        chk(d, 16'h0000);
        clockRun <= 1'b0;
        cycles(40);
        chk({15'h0000, irq}, 16'h0001);
        frameOn <= 1'b0;
        rd(ADDR_IRQ_STAT, d);
        chk(d, 16'h0008);
        wr(ADDR_IRQ_CLR, 16'h0008);
    endtask
    task automatic t_ready_pin;
        wr(ADDR_MODE, 16'h0514);
        @(posedge clk);
        chanNewData <= 8'h01;
        @(posedge clk);
        chanNewData <= 8'h00;
        cycles(2);
        chk({14'h0000, readyPinOeN, readyPinOut}, 16'h0000);
        @(posedge clk);
        chanDataTaken <= 8'h01;
        @(posedge clk);
        chanDataTaken <= 8'h00;
        cycles(2);
        chk({15'h0000, readyPinOut}, 16'h0001);
        // Lagging source: both enabled channels must be ready
        wr(ADDR_MODE, 16'h0510);
        chanEnable <= 8'h03;
        @(posedge clk);
        chanNewData <= 8'h01;
        @(posedge clk);
        chanNewData <= 8'h00;
        cycles(2);
        chk({15'h0000, readyPinOut}, 16'h0001);
        @(posedge clk);
        chanNewData <= 8'h02;
        @(posedge clk);
        chanNewData <= 8'h00;
        cycles(2);
        chk({15'h0000, readyPinOut}, 16'h0000);
        // Leading source follows the lowest enabled channel only
        wr(ADDR_MODE, 16'h0518);
        chanDataTaken <= 8'h01;
        @(posedge clk);
        chanDataTaken <= 8'h00;
        cycles(2);
        chk({15'h0000, readyPinOut}, 16'h0001);
        @(posedge clk);
        chanEnable <= 8'h02;
        cycles(2);
        chk({15'h0000, readyPinOut}, 16'h0000);
        // Pulse format with floating idle: four cycles low, then released
        @(posedge clk);
        chanDataTaken <= 8'h02;
        @(posedge clk);
        chanDataTaken <= 8'h00;
        wr(ADDR_MODE, 16'h0513);
        cycles(1);
        chk({14'h0000, readyPinOeN, readyPinOut}, 16'h0003);
        @(posedge clk);
        chanNewData <= 8'h02;
        @(posedge clk);
        chanNewData <= 8'h00;
        cycles(1);
        chk({14'h0000, readyPinOeN, readyPinOut}, 16'h0000);
        cycles(3);
        chk({14'h0000, readyPinOeN, readyPinOut}, 16'h0000);
        cycles(1);
        chk({14'h0000, readyPinOeN, readyPinOut}, 16'h0003);
    endtask
    task automatic t_mid_reset;
        wr(ADDR_MODE, 16'h2A0C);
        wr(ADDR_IRQ_EN, 16'h000F);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk({14'h0000, readyPinOeN, readyPinOut}, 16'h0001);
        rd(ADDR_MODE, d);
        chk(d, MODE_RST);
        rd(ADDR_STATUS, d);
        chk(d, STATUS_RST);
        rd(ADDR_IRQ_EN, d);
        chk(d, 16'h0000);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset_and_refusal;
        t_mode_fields;
        t_status_events;
        t_irq_and_timeout;
        t_ready_pin;
        t_mid_reset;
        final_report;
    end
endmodule // adcsm_regs_tb
